// *** bfhp_pkg.sv ***
package bfhp_pkg;

  // ------------------------------------------------------------
  // widths and depths
  // ------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int BUF_DEPTH = 4096;
  localparam int FIFO_DEPTH_DEF = 16;

  // ------------------------------------------------------------
  // timing, in picoseconds, and derived cycle counts
  // ------------------------------------------------------------
  localparam int MCLK_PERIOD_PS = 25000;
  localparam int IFCLK_PERIOD_PS = 16670;
  // half period rounds down, and here comes out as zero cycles
  localparam int IFCLK_HALF_RAW = (IFCLK_PERIOD_PS / 2) / MCLK_PERIOD_PS;
  // pins need two sync stages, so the half period can not be shorter than two cycles
  localparam int IFCLK_HALF_CYC = (IFCLK_HALF_RAW < 2) ? 2 : IFCLK_HALF_RAW;
  localparam int STROBE_PULSE_PS = 30000;
  localparam int ASYNC_HOLD_PS = 49000;
  // least time, rounded up
  localparam int ASYNC_HOLD_CYC = (ASYNC_HOLD_PS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] DATA_RST = 8'h00;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic oe_n;
    logic [DATA_W-1:0] data;
  } bfhp_pins_type;

  typedef enum logic [1:0] {DIR_IDLE, DIR_READ, DIR_WRITE} bfhp_dir_type;

endpackage

// *** bfhp_sync.sv ***
module bfhp_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;

  // two-stage synchroniser; idle pins read high after reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '1;
      q <= '1;
    end else if (ce) begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule

// *** bfhp_fifo.sv ***
module bfhp_fifo #(
  parameter int WIDTH = bfhp_pkg::DATA_W,
  parameter int DEPTH = bfhp_pkg::FIFO_DEPTH_DEF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  output logic in_more,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic out_more,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [CW-1:0] count;

  // pointer wrap used by both sides
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // status and handshakes
  wire do_push = in_valid && in_ready;
  wire do_pop = out_valid && out_ready;
  assign in_ready = (count != CW'(DEPTH));
  assign in_more = (count < CW'(DEPTH - 1));
  assign out_valid = (count != '0);
  assign out_more = (count > CW'(1));
  assign out_data = mem[rd_idx];

  // storage is not reset: only pointers and the fill count carry control state
  always_ff @(posedge mclk) begin
    if (ce && do_push) begin
      mem[wr_idx] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
    end else if (ce) begin
      if (do_push) wr_idx <= bump(wr_idx);
      if (do_pop) rd_idx <= bump(rd_idx);
      count <= count + CW'(do_push) - CW'(do_pop);
    end
  end

endmodule

// *** bfhp_port.sv ***
// Overview of operation
// - synchronous mode is a single-channel clocked mode for high transfer rates.
// - in synchronous mode the block drives a free-running interface clock.
// - transfers happen on interface clock rising edges; one direction at a time.
// - data-available flag goes low on the interface clock when bytes are queued.
// - first queued byte stands on the bus once output enable is low.
// - bus advances to next byte on the edge after read strobe sampled low.
// - data-available goes high when empty; host ignores the bus afterwards.
// - a byte is taken only when space flag and write strobe are both low.
// - synchronous writes may burst one byte per clock while space stays.
// - asynchronous mode moves bytes on falling edges of the strobes.
// - asynchronous mode has no clock out, no output enable; read strobe drives bus.
// - after an asynchronous read, data-available stays inactive about 49 ns.
// - after an asynchronous write, space flag stays inactive about 49 ns.
// - separate transmit and receive buffers, 4 Kbytes deep by default.
module bfhp_port #(
  parameter int RX_DEPTH = bfhp_pkg::BUF_DEPTH,
  parameter int TX_DEPTH = bfhp_pkg::BUF_DEPTH,
  parameter int HALF_CYC = bfhp_pkg::IFCLK_HALF_CYC,
  parameter int HOLD_CYC = bfhp_pkg::ASYNC_HOLD_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // configuration level, same clock domain
  input wire logic sync_mode,
  // bytes headed to the external system
  input wire logic rx_in_valid,
  output logic rx_in_ready,
  input wire logic [7:0] rx_in_data,
  // bytes taken from the external system
  output logic tx_out_valid,
  input wire logic tx_out_ready,
  output logic [7:0] tx_out_data,
  // link pins
  output logic interface_clock_out,
  output logic rx_data_available_n,
  output logic tx_space_available_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic out_enable_n,
  // shared data bus
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n
);

  localparam int DW = $clog2(HALF_CYC) + 1;
  localparam int HW = $clog2(HOLD_CYC + 1);

  // ------------------------------------------------------------
  // pin synchronisation and edge detection
  // ------------------------------------------------------------
  bfhp_pkg::bfhp_pins_type pins_raw;
  bfhp_pkg::bfhp_pins_type pins_s;
  logic rd_q;
  logic wr_q;

  assign pins_raw = {read_strobe_n, write_strobe_n, out_enable_n, data_in};

  bfhp_sync #(
    .WIDTH($bits(bfhp_pkg::bfhp_pins_type))
  ) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .d(pins_raw),
    .q(pins_s)
  );

  // previous strobe levels for edge finding
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_q <= 1'b1;
      wr_q <= 1'b1;
    end else if (ce) begin
      rd_q <= pins_s.rd_n;
      wr_q <= pins_s.wr_n;
    end
  end

  wire async_on = ce && !sync_mode;
  wire rd_fall = async_on && rd_q && !pins_s.rd_n;
  wire rd_rise = async_on && !rd_q && pins_s.rd_n;
  wire wr_fall = async_on && wr_q && !pins_s.wr_n;
  wire wr_rise = async_on && !wr_q && pins_s.wr_n;

  // ------------------------------------------------------------
  // interface clock divider
  // ------------------------------------------------------------
  logic [DW-1:0] div_cnt;
  wire div_last = (div_cnt == DW'(HALF_CYC - 1));
  // one-cycle marker of each rising edge of the interface clock
  wire link_rise = ce && sync_mode && div_last && !interface_clock_out;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= '0;
      interface_clock_out <= 1'b0;
    end else if (ce) begin
      if (!sync_mode) begin
        div_cnt <= '0;
        interface_clock_out <= 1'b0;
      end else if (div_last) begin
        div_cnt <= '0;
        interface_clock_out <= ~interface_clock_out;
      end else begin
        div_cnt <= div_cnt + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // buffers
  // ------------------------------------------------------------
  logic rx_valid;
  logic rx_more;
  logic [7:0] rx_head;
  logic tx_ready;
  logic tx_more;
  logic rx_pop;
  logic tx_push;

  // receive buffer, deep enough for a full packet stream
  bfhp_fifo #(
    .WIDTH(bfhp_pkg::DATA_W),
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .in_valid(rx_in_valid),
    .in_ready(rx_in_ready),
    .in_more(),
    .in_data(rx_in_data),
    .out_valid(rx_valid),
    .out_ready(rx_pop),
    .out_more(rx_more),
    .out_data(rx_head)
  );

  // transmit buffer; a stalled drain side backs up into the space flag
  bfhp_fifo #(
    .WIDTH(bfhp_pkg::DATA_W),
    .DEPTH(TX_DEPTH)
  ) u_tx_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .in_valid(tx_push),
    .in_ready(tx_ready),
    .in_more(tx_more),
    .in_data(pins_s.data),
    .out_valid(tx_out_valid),
    .out_ready(tx_out_ready),
    .out_more(),
    .out_data(tx_out_data)
  );

  // ------------------------------------------------------------
  // direction tracking in synchronous mode
  // ------------------------------------------------------------
  bfhp_pkg::bfhp_dir_type dir;
  bfhp_pkg::bfhp_dir_type next_dir;

  // one direction owns the bus until its strobe or enable is released
  always_comb begin
    next_dir = dir;
    case (dir)
      bfhp_pkg::DIR_IDLE: begin
        if (link_rise && !pins_s.oe_n) next_dir = bfhp_pkg::DIR_READ;
        else if (link_rise && !pins_s.wr_n) next_dir = bfhp_pkg::DIR_WRITE;
      end
      bfhp_pkg::DIR_READ: begin
        if (link_rise && pins_s.oe_n) next_dir = bfhp_pkg::DIR_IDLE;
      end
      bfhp_pkg::DIR_WRITE: begin
        if (link_rise && pins_s.wr_n) next_dir = bfhp_pkg::DIR_IDLE;
      end
      default: next_dir = bfhp_pkg::DIR_IDLE;
    endcase
    if (!sync_mode) next_dir = bfhp_pkg::DIR_IDLE;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) dir <= bfhp_pkg::DIR_IDLE;
    else if (ce) dir <= next_dir;
  end

  // ------------------------------------------------------------
  // transfer decode
  // ------------------------------------------------------------
  // the clocked path only runs while synchronous mode is selected
  // a read strobe sampled low on an edge retires the shown byte
  wire sync_pop = link_rise && !rx_data_available_n && !pins_s.oe_n && !pins_s.rd_n &&
                  (dir != bfhp_pkg::DIR_WRITE);
  // taken only with space flag and write strobe both low
  // back-to-back edges each take a byte
  wire sync_push = link_rise && !tx_space_available_n && !pins_s.wr_n && pins_s.oe_n &&
                   (dir != bfhp_pkg::DIR_READ);
  // asynchronous moves follow the strobe falling edges
  assign rx_pop = rx_valid && (sync_pop || (rd_fall && !rx_data_available_n));
  assign tx_push = tx_ready && (sync_push || (wr_fall && !tx_space_available_n));

  // ------------------------------------------------------------
  // recovery holds after asynchronous strobes
  // ------------------------------------------------------------
  logic [HW-1:0] rd_hold;
  logic [HW-1:0] wr_hold;

  // quiet time after a read strobe
  // quiet time after a write strobe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_hold <= '0;
      wr_hold <= '0;
    end else if (ce) begin
      if (rd_rise) rd_hold <= HW'(HOLD_CYC);
      else if (rd_hold != '0) rd_hold <= rd_hold - 1'b1;
      if (wr_rise) wr_hold <= HW'(HOLD_CYC);
      else if (wr_hold != '0) wr_hold <= wr_hold - 1'b1;
    end
  end

  // ------------------------------------------------------------
  // flags
  // ------------------------------------------------------------
  logic next_rxf;
  logic next_txe;

  // low whenever a byte remains after this edge
  // high once the last byte is gone
  // space flag follows buffer room after this edge
  // flags look ahead one byte so a burst never runs past the end
  assign next_rxf = sync_mode ?
                    (link_rise ? !(rx_pop ? rx_more : rx_valid) : rx_data_available_n) :
                    (rd_rise || (rd_hold != '0) || !rx_valid);
  assign next_txe = sync_mode ?
                    (link_rise ? !(tx_push ? tx_more : tx_ready) : tx_space_available_n) :
                    (!pins_s.wr_n || wr_rise || (wr_hold != '0) || !tx_ready);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_data_available_n <= 1'b1;
      tx_space_available_n <= 1'b1;
    end else if (ce) begin
      rx_data_available_n <= next_rxf;
      tx_space_available_n <= next_txe;
    end
  end

  // ------------------------------------------------------------
  // data bus
  // ------------------------------------------------------------
  // head byte is on the bus before any read strobe is seen
  // the byte is frozen while an asynchronous read strobe is low
  // an empty buffer keeps the last byte: unwritten storage never reaches the pins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) data_out <= bfhp_pkg::DATA_RST;
    else if (ce && rx_valid && !(!sync_mode && !pins_s.rd_n)) data_out <= rx_head;
  end

  // drive only under output enable in synchronous mode
  // read strobe alone opens the bus in asynchronous mode
  assign data_oe_n = sync_mode ? pins_s.oe_n : pins_s.rd_n;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_clk_toggle;
    (ce && sync_mode && div_last) |=> $changed(interface_clock_out);
  endproperty
  a_clk_toggle: assert property (p_clk_toggle) else $error("clock out failed to toggle");

  property p_no_clk_async;
    (!sync_mode && $past(!sync_mode)) |-> !interface_clock_out;
  endproperty
  a_no_clk_async: assert property (p_no_clk_async) else $error("clock out in async mode");

  property p_rxf_low;
    (link_rise && rx_valid && !rx_pop) |=> !rx_data_available_n;
  endproperty
  a_rxf_low: assert property (p_rxf_low) else $error("data-available not asserted");

  property p_rxf_empty;
    (link_rise && !rx_valid) |=> rx_data_available_n;
  endproperty
  a_rxf_empty: assert property (p_rxf_empty) else $error("data-available low while empty");

  property p_one_dir;
    !(rx_pop && tx_push);
  endproperty
  a_one_dir: assert property (p_one_dir) else $error("read and write together");

  property p_push_cond;
    (tx_push && sync_mode) |-> (!tx_space_available_n && !pins_s.wr_n && link_rise);
  endproperty
  a_push_cond: assert property (p_push_cond) else $error("byte taken without handshake");

  property p_full_txe;
    (link_rise && !tx_ready) |=> tx_space_available_n;
  endproperty
  a_full_txe: assert property (p_full_txe) else $error("space flag low while full");

  property p_advance;
    (ce && sync_mode && $past(ce) && $past(sync_mode) && $past(rx_valid)) |->
      (data_out == $past(rx_head));
  endproperty
  a_advance: assert property (p_advance) else $error("bus not following head byte");

  property p_rd_hold;
    rd_rise |=> rx_data_available_n [*2];
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read recovery too short");

  property p_wr_hold;
    wr_rise |=> tx_space_available_n [*2];
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write recovery too short");

  property p_bus_drive;
    !data_oe_n |-> (sync_mode ? !pins_s.oe_n : !pins_s.rd_n);
  endproperty
  a_bus_drive: assert property (p_bus_drive) else $error("bus driven without enable");

  property p_async_pop;
    (rd_fall && !rx_data_available_n && rx_valid) |-> rx_pop;
  endproperty
  a_async_pop: assert property (p_async_pop) else $error("async read missed");

  c_sync_read: cover property (sync_pop ##[1:8] sync_pop);
  c_sync_write: cover property (sync_push ##[1:8] sync_push);
  c_async_read: cover property (rd_fall && rx_pop);
  c_async_write: cover property (wr_fall && tx_push);

endmodule

// *** bfhp_host.sv ***
module bfhp_host (
  // sampling clock
  input wire logic mclk,
  // device flags and bus
  input wire logic interface_clock_out,
  input wire logic rx_data_available_n,
  input wire logic tx_space_available_n,
  input wire logic [7:0] bus,
  // host pins
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic out_enable_n,
  output logic drive,
  output logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic last_clk;
  logic last_rxf;
  logic last_txe;
  logic [7:0] first_byte;
  int gap;

  // --------------------
  // pins and link clock
  // --------------------
  // idle pins, bus released
  initial begin
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    out_enable_n = 1'b1;
    drive = 1'b0;
    wdata = 8'h00;
  end
  // link clock seen through mclk, as any outside sampler would
  // flags as they stood at the link edge: they change right after it
  always @(posedge mclk) begin
    last_clk <= interface_clock_out;
    last_rxf <= rx_data_available_n;
    last_txe <= tx_space_available_n;
  end

  task automatic rise();
    do @(posedge mclk); while (!(interface_clock_out && !last_clk));
  endtask

  // --------------------
  // synchronous transfers
  // --------------------
  // enable low before strobe
  task automatic sync_read(input int n, input bit pause, ref logic [7:0] q[$]);
    q.delete();
    do rise(); while (rx_data_available_n);
    out_enable_n <= 1'b0;
    rise();
    first_byte = bus;
    read_strobe_n <= 1'b0;
    forever begin
      rise();
      // bus ignored once flag was high at the edge
      if (last_rxf) break;
      if (!read_strobe_n) q.push_back(bus);
      if (q.size() == n) break;
      read_strobe_n <= pause ? !read_strobe_n : 1'b0;
    end
    read_strobe_n <= 1'b1;
    out_enable_n <= 1'b1;
  endtask

  // enable stays high, so only writes run
  task automatic sync_write(ref logic [7:0] q[$], output int took);
    int idle;
    took = 0;
    idle = 0;
    forever begin
      rise();
      // taken only when both are low
      if (!write_strobe_n && !last_txe) took++;
      idle = tx_space_available_n ? idle + 1 : 0;
      if (took == q.size() || idle > 6) break;
      drive <= 1'b1;
      wdata <= q[took];
      write_strobe_n <= tx_space_available_n;
    end
    write_strobe_n <= 1'b1;
    drive <= 1'b0;
  endtask

  // --------------------
  // asynchronous transfers
  // --------------------
  // flag must first leave its active level, then its inactive time is counted
  task automatic measure(input bit tx);
    gap = 0;
    repeat (10) begin
      @(posedge mclk);
      if (tx ? tx_space_available_n : rx_data_available_n) break;
    end
    while ((tx ? tx_space_available_n : rx_data_available_n) && gap < 20) begin
      @(posedge mclk);
      gap++;
    end
  endtask

  // strobe as soon as flag is low
  task automatic async_read(ref logic [7:0] q[$]);
    do @(posedge mclk); while (rx_data_available_n);
    read_strobe_n <= 1'b0;
    // pulse long enough for the pin synchroniser
    repeat (4) @(posedge mclk);
    q.push_back(bus);
    read_strobe_n <= 1'b1;
    measure(1'b0);
  endtask

  task automatic async_write(input logic [7:0] b);
    do @(posedge mclk); while (tx_space_available_n);
    wdata <= b;
    drive <= 1'b1;
    @(posedge mclk);
    write_strobe_n <= 1'b0;
    // pulse long enough for the pin synchroniser
    repeat (4) @(posedge mclk);
    write_strobe_n <= 1'b1;
    @(posedge mclk);
    drive <= 1'b0;
    measure(1'b1);
  endtask
endmodule

// *** bfhp_port_bench.sv ***
module bfhp_port_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------
  // signals
  // --------------------
  // short buffers keep fill and drain runs brief
  localparam int DEPTH = 16;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic sync_mode = 1'b0;
  logic rx_in_valid = 1'b0;
  logic tx_out_ready = 1'b0;
  logic [7:0] rx_in_data = 8'h00;
  logic [7:0] bus_last = 8'h00;
  logic rx_in_ready, tx_out_valid, interface_clock_out, data_oe_n;
  logic rx_data_available_n, tx_space_available_n;
  logic read_strobe_n, write_strobe_n, out_enable_n, drive;
  logic [7:0] tx_out_data, data_out, wdata, bus;
  logic [7:0] got[$];
  logic [7:0] sent[$];
  int failures = 0;
  int n_tests = 0;
  int cnt;

  always #12.5 mclk = ~mclk;
  // a released bus has no pull, so it shows a pattern that moves each cycle
  assign bus = !data_oe_n ? data_out : drive ? wdata : ~bus_last;
  always @(posedge mclk) bus_last <= bus;

  bfhp_port #(.RX_DEPTH(DEPTH), .TX_DEPTH(DEPTH)) dut_u (
    .mclk(mclk), .reset_n(reset_n), .ce(1'b1), .sync_mode(sync_mode),
    .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready), .rx_in_data(rx_in_data),
    .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready), .tx_out_data(tx_out_data),
    .interface_clock_out(interface_clock_out), .rx_data_available_n(rx_data_available_n),
    .tx_space_available_n(tx_space_available_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .out_enable_n(out_enable_n),
    .data_in(bus), .data_out(data_out), .data_oe_n(data_oe_n));

  bfhp_host host_u (
    .mclk(mclk), .interface_clock_out(interface_clock_out),
    .rx_data_available_n(rx_data_available_n), .tx_space_available_n(tx_space_available_n),
    .bus(bus), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .out_enable_n(out_enable_n), .drive(drive), .wdata(wdata));

  // --------------------
  // helpers
  // --------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask

  // offer up to n bytes, stopping early if refused; cnt holds how many went in
  task automatic fill(input int n);
    cnt = 0;
    sent.delete();
    while (cnt < n) begin
      rx_in_valid <= 1'b1;
      rx_in_data <= 8'ha0 + 8'(cnt);
      @(posedge mclk);
      if (rx_in_ready !== 1'b1) break;
      sent.push_back(rx_in_data);
      cnt++;
    end
    rx_in_valid <= 1'b0;
  endtask

  task automatic drain();
    got.delete();
    tx_out_ready <= 1'b1;
    repeat (40) begin
      @(posedge mclk);
      if (tx_out_valid === 1'b1) got.push_back(tx_out_data);
    end
    tx_out_ready <= 1'b0;
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // --------------------
  // scenarios
  // --------------------
  task automatic test_async();
    cnt = 0;
    repeat (40) begin
      @(posedge mclk);
      cnt += interface_clock_out;
    end
    chk(8'(cnt), 8'h00);
    fill(2);
    got.delete();
    for (int i = 0; i < 2; i++) begin
      host_u.async_read(got);
      chk(got[i], sent[i]);
      chk(8'(host_u.gap >= bfhp_pkg::ASYNC_HOLD_CYC), 8'h01);
    end
    sent = '{8'h5a, 8'hc3};
    for (int i = 0; i < 2; i++) begin
      host_u.async_write(sent[i]);
      chk(8'(host_u.gap >= bfhp_pkg::ASYNC_HOLD_CYC), 8'h01);
    end
    drain();
    chk(8'(got.size()), 8'h02);
    for (int i = 0; i < 2; i++) chk(got[i], sent[i]);
  endtask

  task automatic test_sync();
    // mode switched only after asynchronous use
    sync_mode <= 1'b1;
    repeat (8) @(posedge mclk);
    cnt = 0;
    repeat (80) begin
      @(posedge mclk);
      cnt += (interface_clock_out && !host_u.last_clk);
    end
    chk(8'(cnt), 8'(80 / (2 * bfhp_pkg::IFCLK_HALF_CYC)));
    fill(DEPTH + 4);
    chk(8'(cnt), 8'(DEPTH));
    host_u.sync_read(DEPTH, 1'b0, got);
    chk(host_u.first_byte, sent[0]);
    for (int i = 0; i < DEPTH; i++) chk(got[i], sent[i]);
    repeat (6) @(posedge mclk);
    chk({7'h00, rx_data_available_n}, 8'h01);
    // ask for more than is queued, with a wait state after each byte
    fill(3);
    host_u.sync_read(5, 1'b1, got);
    chk(8'(got.size()), 8'h03);
    for (int i = 0; i < 3; i++) chk(got[i], sent[i]);
    // drain side stalls, so the transmit buffer fills and refuses
    sent.delete();
    for (int i = 0; i < DEPTH + 4; i++) sent.push_back(8'h30 + 8'(i));
    host_u.sync_write(sent, cnt);
    chk(8'(cnt), 8'(DEPTH));
    chk({7'h00, tx_space_available_n}, 8'h01);
    drain();
    chk(8'(got.size()), 8'(DEPTH));
    for (int i = 0; i < DEPTH; i++) chk(got[i], sent[i]);
    repeat (8) @(posedge mclk);
    chk({7'h00, tx_space_available_n}, 8'h00);
  endtask

  // --------------------
  // main sequence and watchdog
  // --------------------
  initial begin
    repeat (8) @(posedge mclk);
    chk({2'b00, interface_clock_out, rx_data_available_n, tx_space_available_n,
         data_oe_n, rx_in_ready, tx_out_valid}, 8'h1e);
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    test_async();
    test_sync();
    complete_run();
  end

  // whole run needs well under two thousand cycles
  initial begin
    repeat (6000) @(posedge mclk);
    failures++;
    complete_run();
  end
endmodule
